// file: core/rssq_defs.vh
// constants for the root startup sync sequencer
`ifndef RSSQ_DEFS_VH
`define RSSQ_DEFS_VH

// ==========================================
// clock and timing
`define RSSQ_MCLK_HZ 25000000
`define RSSQ_CYC_PER_US (`RSSQ_MCLK_HZ / 1000000)
`define RSSQ_READY_WAIT_US 10000
`define RSSQ_WAIT_MARGIN_US 1000
`define RSSQ_SYNC_TIMEOUT_US 1000
`define RSSQ_DEBOUNCE_US 5000
`define RSSQ_CNT_W 24

// ==========================================
// command kinds on the host command port
`define RSSQ_KIND_XCVR 2'h0
`define RSSQ_KIND_EXP_CFG 2'h1
`define RSSQ_KIND_EXP_OUT 2'h2

// ==========================================
// transceiver and expander addresses
`define RSSQ_XCVR_DEV_ADDR 7'h00
`define RSSQ_XCVR_CTRL_REG 8'h12
`define RSSQ_ROOT_BIT 8'h01
`define RSSQ_EXP_DEV_ADDR 7'h41
`define RSSQ_EXP_OUT_REG 8'h01
`define RSSQ_EXP_CFG_REG 8'h03
`define RSSQ_EXP_CFG_PINS01_OUT 8'hFC
`define RSSQ_EXP_PIN1_LOW 8'h00
`define RSSQ_EXP_PIN1_HIGH 8'h02
`define RSSQ_EXP_PIN1_BIT 1

// ==========================================
// bit clock / tdm jumper codes
`define RSSQ_TDM2 2'h0
`define RSSQ_TDM4 2'h1
`define RSSQ_TDM8 2'h2
`define RSSQ_BCLK_TDM2_HZ 24'h2EE000
`define RSSQ_BCLK_TDM4_HZ 24'h5DC000
`define RSSQ_BCLK_TDM8_HZ 24'hBB8000

`endif

// file: core/rssq_sequencer.v
// root startup sync sequencer: root role write, sync gating, ready wait, gpio conventions
//
// Operation
// (RQ1) frame sync stays gated off until the root-role control write completes.
// (RQ2) after sync is applied, wait about ten milliseconds before reporting ready; the local-clock board sets xcvr_ready as sync_gate opens.
// (RQ3) expander commands carry 7-bit device address 0x41.
// (RQ4) external-clock board: expander pin one low passes sync and lights run.
// (RQ5) expander pin zero drives the red host light, lit at zero.
// (RQ6) order: root write, enable sync with pin one low, wait, continue.
// (RQ7) root role is set by writing control register 0x12 before sync.
// (RQ8) sync absent past timeout resets transceiver state; await root write again.
// (RQ9) once sync runs, root role is locked and cannot be changed.
// (RQ10) local-clock board: pin one high enables the oscillator and green run light.
// (RQ11) expander pins zero and one are configured as outputs first.
// (RQ12) jumper selects TDM8, TDM4 or TDM2 bit clock, 32-bit slots at 48 kHz.
// (RQ13) local-clock board defaults to TDM2 unless jumper selects TDM4 or TDM8.
// (RQ14) local board: after the wait drive pin one high, then continue.
// (RQ15) only frame sync is needed from the external source, no data.
// (RQ16) pushbutton on transceiver gpio seven is debounced before use.
// (RQ17) user light follows its transceiver gpio directly, one lights it.
// (RQ18) ready wait is counted on the own clock with margin.
`timescale 1ns/1ps
`default_nettype none
`include "rssq_defs.vh"

module rssq_sequencer #(
	parameter READY_WAIT_CYCLES = `RSSQ_CYC_PER_US * `RSSQ_READY_WAIT_US,
	parameter WAIT_MARGIN_CYCLES = `RSSQ_CYC_PER_US * `RSSQ_WAIT_MARGIN_US,
	parameter SYNC_TIMEOUT_CYCLES = `RSSQ_CYC_PER_US * `RSSQ_SYNC_TIMEOUT_US,
	parameter DEBOUNCE_CYCLES = `RSSQ_CYC_PER_US * `RSSQ_DEBOUNCE_US
) (
	// clock and reset
	input wire mclk,
	input wire rst,
	// control
	input wire start,
	input wire local_clock_board,
	input wire [1:0] tdm_jumper,
	// command port toward i2c engine
	output reg cmd_valid,
	output reg [1:0] cmd_kind,
	output reg [6:0] cmd_dev_addr,
	output reg [7:0] cmd_reg,
	output reg [7:0] cmd_data,
	input wire cmd_done,
	// frame sync
	input wire sync_in,
	output reg sync_out,
	// status
	output reg root_written,
	output reg root_locked,
	output reg xcvr_ready,
	output reg xcvr_reset,
	output reg [1:0] tdm_mode,
	output reg [23:0] bit_clock_hz,
	// gpio conventions
	input wire transceiver_gpio_seven,
	input wire user_gpio,
	output reg button_pressed,
	output reg user_led
);

	localparam ST_IDLE = 3'h0;
	localparam ST_ROOT = 3'h1;
	localparam ST_CFG = 3'h2;
	localparam ST_OUT0 = 3'h3;
	localparam ST_WAIT = 3'h4;
	localparam ST_OUT1 = 3'h5;
	localparam ST_READY = 3'h6;

	localparam integer WAIT_TOTAL_N = READY_WAIT_CYCLES + WAIT_MARGIN_CYCLES;
	localparam integer SYNC_TO_N = SYNC_TIMEOUT_CYCLES;
	localparam integer DEB_TOTAL_N = DEBOUNCE_CYCLES;
	// counts cut to the counter width on purpose; the defaults fit well inside it
	localparam [`RSSQ_CNT_W-1:0] WAIT_TOTAL = WAIT_TOTAL_N[`RSSQ_CNT_W-1:0];
	localparam [`RSSQ_CNT_W-1:0] SYNC_TO = SYNC_TO_N[`RSSQ_CNT_W-1:0];
	localparam [`RSSQ_CNT_W-1:0] DEB_TOTAL = DEB_TOTAL_N[`RSSQ_CNT_W-1:0];

	reg [2:0] state;
	reg [`RSSQ_CNT_W-1:0] wait_cnt;
	reg [`RSSQ_CNT_W-1:0] idle_cnt;
	reg sync_gate;
	reg sync_prev;
	reg [`RSSQ_CNT_W-1:0] deb_cnt;
	reg btn_stable;

	// ==========================================
	// startup sequence
	// each step holds cmd_valid until the i2c engine reports done
	always @(posedge mclk) begin
		if (rst) begin
			state <= ST_IDLE;
			cmd_valid <= 1'b0;
			cmd_kind <= `RSSQ_KIND_XCVR;
			cmd_dev_addr <= `RSSQ_XCVR_DEV_ADDR;
			cmd_reg <= 8'h00;
			cmd_data <= 8'h00;
			wait_cnt <= {`RSSQ_CNT_W{1'b0}};
			sync_gate <= 1'b0;
			root_written <= 1'b0;
			root_locked <= 1'b0;
			xcvr_ready <= 1'b0;
			xcvr_reset <= 1'b0;
		end else begin
			xcvr_reset <= 1'b0;
			case (state)
			ST_IDLE: begin
				sync_gate <= 1'b0; // RQ1
				if (start && !root_locked) begin // RQ9
					cmd_valid <= 1'b1;
					cmd_kind <= `RSSQ_KIND_XCVR;
					cmd_dev_addr <= `RSSQ_XCVR_DEV_ADDR;
					cmd_reg <= `RSSQ_XCVR_CTRL_REG; // RQ7
					cmd_data <= `RSSQ_ROOT_BIT;
					state <= ST_ROOT;
				end
			end
			ST_ROOT: begin
				if (cmd_done) begin
					root_written <= 1'b1;
					cmd_kind <= `RSSQ_KIND_EXP_CFG;
					cmd_dev_addr <= `RSSQ_EXP_DEV_ADDR; // RQ3
					cmd_reg <= `RSSQ_EXP_CFG_REG;
					cmd_data <= `RSSQ_EXP_CFG_PINS01_OUT; // RQ11
					state <= ST_CFG;
				end
			end
			ST_CFG: begin
				if (cmd_done) begin
					cmd_kind <= `RSSQ_KIND_EXP_OUT;
					cmd_reg <= `RSSQ_EXP_OUT_REG;
					cmd_data <= `RSSQ_EXP_PIN1_LOW; // RQ5 RQ6
					state <= ST_OUT0;
				end
			end
			ST_OUT0: begin
				if (cmd_done) begin
					cmd_valid <= 1'b0;
					sync_gate <= !local_clock_board; // RQ4 RQ15
					wait_cnt <= {`RSSQ_CNT_W{1'b0}};
					state <= ST_WAIT;
				end
			end
			ST_WAIT: begin
				if (wait_cnt == WAIT_TOTAL - 1'b1) begin // RQ2 RQ18
					if (local_clock_board) begin
						cmd_valid <= 1'b1;
						cmd_data <= `RSSQ_EXP_PIN1_HIGH; // RQ10 RQ14
						state <= ST_OUT1;
					end else begin
						xcvr_ready <= 1'b1; // RQ6
						state <= ST_READY;
					end
				end else begin
					wait_cnt <= wait_cnt + 1'b1;
				end
			end
			ST_OUT1: begin
				if (cmd_done) begin
					cmd_valid <= 1'b0;
					sync_gate <= 1'b1; // RQ10
					xcvr_ready <= 1'b1; // RQ14
					state <= ST_READY;
				end
			end
			ST_READY: begin
				if (sync_in && sync_gate)
					root_locked <= 1'b1; // RQ9
				if (idle_cnt == SYNC_TO - 1'b1) begin // RQ8
					xcvr_ready <= 1'b0;
					root_written <= 1'b0;
					root_locked <= 1'b0;
					sync_gate <= 1'b0;
					xcvr_reset <= 1'b1;
					state <= ST_IDLE;
				end
			end
			default: begin
				state <= ST_IDLE;
			end
			endcase
		end
	end

	// ==========================================
	// gated sync and absence timer
	always @(posedge mclk) begin
		if (rst) begin
			sync_out <= 1'b0;
			sync_prev <= 1'b0;
			idle_cnt <= {`RSSQ_CNT_W{1'b0}};
		end else begin
			sync_out <= sync_in & sync_gate; // RQ1 RQ4
			sync_prev <= sync_in;
			if (state != ST_READY || (sync_in != sync_prev))
				idle_cnt <= {`RSSQ_CNT_W{1'b0}}; // RQ8
			else if (idle_cnt != SYNC_TO - 1'b1)
				idle_cnt <= idle_cnt + 1'b1;
		end
	end

	// ==========================================
	// bit clock / tdm selection, invalid codes fall back to tdm2
	always @(posedge mclk) begin
		if (rst) begin
			tdm_mode <= `RSSQ_TDM2; // RQ13
			bit_clock_hz <= `RSSQ_BCLK_TDM2_HZ;
		end else begin
			case (tdm_jumper)
			`RSSQ_TDM4: begin
				tdm_mode <= `RSSQ_TDM4; // RQ12
				bit_clock_hz <= `RSSQ_BCLK_TDM4_HZ;
			end
			`RSSQ_TDM8: begin
				tdm_mode <= `RSSQ_TDM8; // RQ12
				bit_clock_hz <= `RSSQ_BCLK_TDM8_HZ;
			end
			default: begin
				tdm_mode <= `RSSQ_TDM2; // RQ13
				bit_clock_hz <= `RSSQ_BCLK_TDM2_HZ;
			end
			endcase
		end
	end

	// ==========================================
	// pushbutton debounce and user light
	// button is active low on the gpio; accepted only after a stable period
	always @(posedge mclk) begin
		if (rst) begin
			deb_cnt <= {`RSSQ_CNT_W{1'b0}};
			btn_stable <= 1'b1;
			button_pressed <= 1'b0;
			user_led <= 1'b0;
		end else begin
			user_led <= user_gpio; // RQ17
			button_pressed <= !btn_stable;
			if (transceiver_gpio_seven == btn_stable)
				deb_cnt <= {`RSSQ_CNT_W{1'b0}};
			else if (deb_cnt == DEB_TOTAL - 1'b1) begin
				btn_stable <= transceiver_gpio_seven; // RQ16
				deb_cnt <= {`RSSQ_CNT_W{1'b0}};
			end else
				deb_cnt <= deb_cnt + 1'b1;
		end
	end

endmodule // rssq_sequencer
`default_nettype wire

// file: tb/rssq_chk_properties.sv
// port checker for the root startup sync sequencer
`timescale 1ns/1ps
`default_nettype none
module rssq_chk #(
	parameter int READY_WAIT = 20
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// command port
	input wire logic cmd_valid,
	input wire logic [1:0] cmd_kind,
	input wire logic [6:0] cmd_dev_addr,
	input wire logic [7:0] cmd_reg,
	input wire logic [7:0] cmd_data,
	// sync and status
	input wire logic sync_out,
	input wire logic root_written,
	input wire logic root_locked,
	input wire logic xcvr_ready,
	input wire logic xcvr_reset,
	input wire logic [1:0] tdm_mode,
	input wire logic [23:0] bit_clock_hz,
	// gpio conventions
	input wire logic transceiver_gpio_seven,
	input wire logic user_gpio,
	input wire logic button_pressed,
	input wire logic user_led
);
	int quiet;
	// ==========
	// cycles since the command port last asked for anything, saturating
	always @(posedge mclk) begin
		if (rst || cmd_valid)
			quiet <= 0;
		else if (quiet < 1000)
			quiet <= quiet + 1;
	end
	// ==========
	// all properties sample on mclk and rest during reset
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	property p_gate; sync_out |-> root_written; endproperty
	a_gate: assert property (p_gate) else $error("sync passed before root write");
	property p_first; $rose(cmd_valid) && !root_written |-> cmd_kind == 2'h0 && cmd_reg == 8'h12 && cmd_data == 8'h01; endproperty
	a_first: assert property (p_first) else $error("first command not root write");
	property p_addr; cmd_valid && cmd_kind != 2'h0 |-> cmd_dev_addr == 7'h41; endproperty
	a_addr: assert property (p_addr) else $error("expander address wrong");
	property p_osc; $rose(cmd_valid) && root_written |-> cmd_kind == 2'h2 && cmd_data == 8'h02; endproperty
	a_osc: assert property (p_osc) else $error("late command not pin one high");
	property p_rdy; $rose(xcvr_ready) |-> $past(cmd_valid) || quiet >= READY_WAIT; endproperty
	a_rdy: assert property (p_rdy) else $error("ready too soon");
	property p_wait; $rose(cmd_valid) && root_written |-> quiet >= READY_WAIT; endproperty
	a_wait: assert property (p_wait) else $error("oscillator started before the wait ran out");
	property p_lock; root_locked |-> !(cmd_valid && cmd_kind == 2'h0); endproperty
	a_lock: assert property (p_lock) else $error("root write while locked");
	property p_rst; xcvr_reset |=> !xcvr_ready && !root_written; endproperty
	a_rst: assert property (p_rst) else $error("status kept after timeout");
	property p_clk; bit_clock_hz == (tdm_mode == 2'h2 ? 24'hBB8000 : tdm_mode == 2'h1 ? 24'h5DC000 : 24'h2EE000); endproperty
	a_clk: assert property (p_clk) else $error("bit clock rate wrong");
	property p_led; 1'b1 |=> user_led == $past(user_gpio); endproperty
	a_led: assert property (p_led) else $error("user light lags");
	// the four samples that led to acceptance lie two to five cycles back
	property p_btn;
		$rose(button_pressed) |-> !$past(transceiver_gpio_seven, 2) && !$past(transceiver_gpio_seven, 3) &&
			!$past(transceiver_gpio_seven, 4) && !$past(transceiver_gpio_seven, 5);
	endproperty
	a_btn: assert property (p_btn) else $error("press not debounced");
	// main scenarios
	c_rdy: cover property (xcvr_ready);
	c_rst: cover property (xcvr_reset);
	c_btn: cover property (button_pressed);
endmodule // rssq_chk
`default_nettype wire

// file: tb/rssq_i2c_model.sv
// command engine model answering transceiver and expander writes
`timescale 1ns/1ps
`default_nettype none
module rssq_i2c_model (
	// clock, reset, pacing
	input wire logic mclk, rst, slow,
	// command port
	input wire logic cmd_valid,
	output logic cmd_done
);
	int n;
	// ==========
	// one-cycle done after a short or long transfer, any address taken
	always @(posedge mclk) begin
		cmd_done <= 1'b0;
		if (rst || !cmd_valid || cmd_done) begin
			n <= 0;
		end else if (n == (slow ? 6 : 1)) begin
			cmd_done <= 1'b1;
			n <= 0;
		end else begin
			n <= n + 1;
		end
	end
endmodule // rssq_i2c_model
`default_nettype wire

// file: tb/tb_top.sv
// self-checking bench of the root startup sync sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic mclk = 0, rst = 1, start = 0, board = 0, slow = 0, cmd_done, sync_in = 0, run_sync = 0;
	logic cmd_valid, sync_out, root_written, root_locked, xcvr_ready, xcvr_reset, btn = 1, ugpio = 0;
	logic pressed, user_led, rst_d = 1, ready_d = 0;
	logic [1:0] jmp = 2'h0, tdm_mode, cmd_kind;
	logic [6:0] dev_addr;
	logic [7:0] cmd_reg, cmd_data;
	logic [23:0] bclk;
	int errors = 0, comparisons = 0, seed = 56761, i, n, b, step = 0;
	localparam int WAIT_CYCLES = 20;
	localparam int MARGIN_CYCLES = 2;
	// ==========
	// clock and partner
	initial forever #20 mclk = ~mclk;
	rssq_i2c_model rssq_i2c_model_inst (.mclk(mclk), .rst(rst), .slow(slow), .cmd_valid(cmd_valid), .cmd_done(cmd_done));
	rssq_sequencer #(.READY_WAIT_CYCLES(WAIT_CYCLES), .WAIT_MARGIN_CYCLES(MARGIN_CYCLES),
		.SYNC_TIMEOUT_CYCLES(50), .DEBOUNCE_CYCLES(4))
	rssq_sequencer_inst (.mclk(mclk), .rst(rst), .start(start), .local_clock_board(board), .tdm_jumper(jmp),
		.cmd_valid(cmd_valid), .cmd_kind(cmd_kind), .cmd_dev_addr(dev_addr), .cmd_reg(cmd_reg),
		.cmd_data(cmd_data), .cmd_done(cmd_done),
		.sync_in(sync_in), .sync_out(sync_out), .root_written(root_written), .root_locked(root_locked),
		.xcvr_ready(xcvr_ready), .xcvr_reset(xcvr_reset), .tdm_mode(tdm_mode), .bit_clock_hz(bclk),
		.transceiver_gpio_seven(btn), .user_gpio(ugpio), .button_pressed(pressed), .user_led(user_led));
	task chk(input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			errors++;
			$display("ERROR %0t exp %h got %h", $time, e, g);
		end
	endtask
	// expected command of each step of the startup order: kind, address, register, data
	function automatic logic [31:0] exp_cmd(input int s);
		case (s)
		0: exp_cmd = {7'h00, 2'h0, 7'h00, 8'h12, 8'h01};
		1: exp_cmd = {7'h00, 2'h1, 7'h41, 8'h03, 8'hFC};
		2: exp_cmd = {7'h00, 2'h2, 7'h41, 8'h01, 8'h00};
		default: exp_cmd = {7'h00, 2'h2, 7'h41, 8'h01, 8'h02};
		endcase
	endfunction
	// expected bit clock rate of a jumper code, unknown codes as tdm2
	function automatic logic [31:0] exp_bclk(input logic [1:0] j);
		case (j)
		2'h1: exp_bclk = 32'h005DC000;
		2'h2: exp_bclk = 32'h00BB8000;
		default: exp_bclk = 32'h002EE000;
		endcase
	endfunction
	task tally_and_finish;
		if (errors == 0 && comparisons > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task hang;
		errors++;
		tally_and_finish;
	endtask
	// random user light and frame sync, checked each falling edge
	always @(negedge mclk) begin
		if (!rst && !rst_d) chk(ugpio, user_led);
		if (!root_written) chk(0, sync_out);
		if (board && root_written && !xcvr_ready) chk(0, sync_out);
		if (xcvr_ready && ready_d && run_sync) chk(sync_in, sync_out);
		if (cmd_valid && cmd_done) begin
			chk(exp_cmd(step), {7'h00, cmd_kind, dev_addr, cmd_reg, cmd_data});
			step <= step + 1;
		end else if (xcvr_reset) begin
			step <= 0;
		end
		rst_d <= rst;
		ready_d <= xcvr_ready;
		ugpio <= $random(seed);
		sync_in <= run_sync ? $random(seed) : 1'b0;
	end
	// ==========
	// main sequence
	initial begin
		repeat (5) @(negedge mclk);
		rst = 0;
		@(negedge mclk);
		chk(0, tdm_mode);
		for (b = 0; b < 4; b++) begin
			board = b[0];
			slow = b[1];
			jmp = (b == 3) ? 2'h3 : $random(seed);
			run_sync = 1;
			start = 1;
			@(negedge mclk);
			start = 0;
			n = 0;
			for (i = 0; i < 400 && !xcvr_ready; i++) begin
				@(negedge mclk);
				if (root_written && !cmd_valid) n++;
			end
			if (!xcvr_ready) hang;
			chk(WAIT_CYCLES + MARGIN_CYCLES + 1, n);
			chk(board ? 4 : 3, step);
			chk((jmp == 2'h3) ? 2'h0 : jmp, tdm_mode);
			chk(exp_bclk(jmp), bclk);
			repeat (20) @(negedge mclk);
			chk(1, root_locked);
			start = 1;
			@(negedge mclk);
			start = 0;
			repeat (2) @(negedge mclk);
			chk(0, cmd_valid);
			run_sync = 0;
			for (i = 0; i < 200 && !xcvr_reset; i++) @(negedge mclk);
			if (!xcvr_reset) hang;
			@(negedge mclk);
			chk(0, root_written | xcvr_ready);
		end
		btn = 0;
		repeat (2) @(negedge mclk);
		btn = 1;
		repeat (8) @(negedge mclk);
		chk(0, pressed);
		btn = 0;
		repeat (10) @(negedge mclk);
		chk(1, pressed);
		btn = 1;
		repeat (10) @(negedge mclk);
		chk(0, pressed);
		tally_and_finish;
	end
endmodule // tb_top
bind rssq_sequencer rssq_chk #(.READY_WAIT(20)) rssq_chk_inst (.*);
`default_nettype wire
